/* fsdi_defines.svh */
// Purpose: named constants for the fractional interpolator
// Assumes: included by bare name
// Notes:   offsets are word byte addresses on the register bus
`ifndef FSDI_DEFINES_SVH
`define FSDI_DEFINES_SVH
`define FSDI_ADR_FEEDBACK   4'h0
`define FSDI_ADR_REFDIV     4'h4
`define FSDI_ADR_NOISE      4'h8
`define FSDI_ADR_CONTROL    4'hc
`define FSDI_ADR_STATUS     4'h0
`define FSDI_ADR_RESULT     4'h4
`define FSDI_MOD_MIN        12'h002
`define FSDI_MOD_RST        12'h002
`define FSDI_INT_RST        16'h0017
`define FSDI_CP_MAX         4'hf
`define FSDI_CP_RST         4'h0
`define FSDI_LFSR_SEED      21'h1a5a5f
`define FSDI_LFSR_TAPS      21'h140000
`define FSDI_PHASE_RST      2'h0
`endif

/* fsdi_pkg.sv */
// Purpose: shared types of the fractional interpolator
// Assumes: fsdi_defines.svh supplies the numbers
// Notes:   mode encodings follow the noise register field
package fsdi_pkg;
  typedef enum logic [1:0] {
    FSDI_LOWEST_NOISE,
    FSDI_NOISE_SPUR,
    FSDI_LOW_SPUR,
    FSDI_MODE_RSV
  } fsdi_mode_t;

  typedef struct packed {
    logic [11:0] acc1;
    logic [11:0] acc2;
    logic [11:0] acc3;
    logic [1:0]  c2_d;
    logic [2:0]  c3_d1;
    logic [2:0]  c3_d2;
  } fsdi_mash_t;

  typedef struct packed {
    logic        stb;
    logic [11:0] modulus;
    logic [11:0] fraction;
    logic        dither;
    logic        restart;
    logic        dbit;
  } fsdi_mash_in_t;
endpackage : fsdi_pkg

/* fsdi_mash.sv */
// Purpose: third-order error-feedback modulator core
// Assumes: modulus within 2..4095, fraction below modulus
// Notes:   carry out is a signed offset -3..+4 on the divide word
`timescale 1ns/10ps
`default_nettype none
`include "fsdi_defines.svh"
module fsdi_mash
  import fsdi_pkg::*;
(
  // clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  // control
  input  wire fsdi_mash_in_t in_i,
  // result
  output logic signed [3:0]  carry_o
);
  fsdi_mash_t st_ff, nxt_st;
  logic signed [3:0] nxt_carry;

  // one accumulator stage, wraps at the programmed modulus
  function automatic logic [12:0] stage(input logic [11:0] a,
                                        input logic [11:0] b,
                                        input logic        lsb,
                                        input logic [11:0] m);
    logic [12:0] s;
    s = {1'b0, a} + {1'b0, b} + {12'h000, lsb};
    if (s >= {1'b0, m}) begin
      stage = {1'b1, 12'(s - {1'b0, m})};
    end else begin
      stage = {1'b0, s[11:0]};
    end
  endfunction : stage

  always_comb begin
    logic [12:0] r1, r2, r3;
    logic signed [3:0] c1, c2, c3;
    r1 = 13'h0000;
    r2 = 13'h0000;
    r3 = 13'h0000;
    c1 = 4'sh0;
    c2 = 4'sh0;
    c3 = 4'sh0;
    nxt_st = st_ff;
    nxt_carry = carry_o;
    if (in_i.restart) begin
      nxt_st = '0;
      nxt_carry = 4'sh0;
    end else if (in_i.stb) begin
      // dither adds a random lsb only on the first stage
      r1 = stage(st_ff.acc1, in_i.fraction, in_i.dither & in_i.dbit,
                 in_i.modulus);
      r2 = stage(st_ff.acc2, r1[11:0], 1'b0, in_i.modulus);
      r3 = stage(st_ff.acc3, r2[11:0], 1'b0, in_i.modulus);
      nxt_st.acc1 = r1[11:0];
      nxt_st.acc2 = r2[11:0];
      nxt_st.acc3 = r3[11:0];
      c1 = {3'h0, r1[12]};
      c2 = {3'h0, r2[12]};
      c3 = {3'h0, r3[12]};
      nxt_st.c2_d = {1'b0, r2[12]};
      nxt_st.c3_d1 = {2'h0, r3[12]};
      nxt_st.c3_d2 = st_ff.c3_d1;
      // noise shaping: c1 + (1-z^-1)c2 + (1-z^-1)^2 c3
      nxt_carry = 4'(c1 + c2 - signed'({2'h0, st_ff.c2_d}) + c3
                  - signed'({1'b0, st_ff.c3_d1}) * 4'sh2
                  + signed'({1'b0, st_ff.c3_d2}));
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= '0;
      carry_o <= 4'sh0;
    end else begin
      st_ff <= nxt_st;
      carry_o <= nxt_carry;
    end
  end
endmodule : fsdi_mash
`default_nettype wire

/* fsdi_top.sv */
// Purpose: fractional interpolator with fastlock and reference doubler
// Assumes: ref_rise_i and ref_fall_i mark reference edges, one cycle pulses
// Notes:   divider and doubler are modelled as edge-rate logic
// Behaviour
// - The modulator is third order and advances once per detector cycle.
// - The modulus may be any integer from 2 to 4095 and the host keeps it so.
// - With dither off the output repeats with a modulus-dependent period.
// - With dither on the quantization is randomised over 2^21-1 cycles.
// - Dither is off in both low noise modes and on only in low spur mode.
// - While fastlock is set the charge pump current is forced to maximum.
// - The fastlock switch closes only if the monitor pin selects it.
// - Clearing fastlock restores programmed current and opens the switch.
// - With the doubler on, both reference edges feed the reference divider.
// - Every feedback load restarts the modulator state the same way.
// - A new modulus latches with the reference write, used on feedback load.
//
// Register access over Wishbone and the address map were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "fsdi_defines.svh"
module fsdi_top
  import fsdi_pkg::*;
#(
  parameter int MOD_W = 12,
  parameter int INT_W = 16
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // wishbone slave
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [3:0]       wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic [31:0]           wb_dat_o,
  output logic                  wb_ack_o,
  // reference edges
  input  wire logic             ref_rise_i,
  input  wire logic             ref_fall_i,
  // synthesizer controls
  output logic                  pd_tick_o,
  output logic [INT_W-1:0]      divide_o,
  output logic [3:0]            cp_current_o,
  output logic                  fl_switch_o
);
  typedef struct packed {
    logic             ack;
    logic [31:0]      rdat;
    logic [INT_W-1:0] int_word;
    logic [MOD_W-1:0] fraction;
    logic             fastlock;
    logic [MOD_W-1:0] mod_staged;
    logic [MOD_W-1:0] mod_active;
    logic [3:0]       rdiv;
    logic             doubler;
    logic [3:0]       cp_prog;
    logic             mon_fl;
    fsdi_mode_t       mode;
    logic [3:0]       rcnt;
    logic             tick;
    logic             restart;
    logic [20:0]      lfsr;
    logic [INT_W-1:0] divide;
    logic [3:0]       cp_out;
    logic             sw_out;
  } fsdi_state_t;

  fsdi_state_t       s_ff, nxt_s;
  fsdi_mash_in_t     mash_in;
  logic signed [3:0] carry;
  logic              wr;
  logic              rd;
  logic              ref_edge;
  logic [3:0]        rlim;

  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~s_ff.ack;
  assign rd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~s_ff.ack;
  // doubler makes both edges active, else only the falling edge
  assign ref_edge = ref_fall_i | (s_ff.doubler & ref_rise_i);
  assign rlim = (s_ff.rdiv == 4'h0) ? 4'h1 : s_ff.rdiv;

  always_comb begin
    mash_in = '0;
    mash_in.stb = s_ff.tick;
    mash_in.modulus = s_ff.mod_active;
    mash_in.fraction = s_ff.fraction;
    mash_in.dither = (s_ff.mode == FSDI_LOW_SPUR);
    mash_in.restart = s_ff.restart;
    mash_in.dbit = s_ff.lfsr[0];
  end

  fsdi_mash u_mash (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .in_i    (mash_in),
    .carry_o (carry)
  );

  always_comb begin
    nxt_s = s_ff;
    nxt_s.ack = 1'b0;
    nxt_s.restart = 1'b0;
    nxt_s.tick = 1'b0;
    if (wr) begin
      nxt_s.ack = 1'b1;
      if (wb_adr_i == `FSDI_ADR_FEEDBACK) begin
        if (wb_sel_i[0]) nxt_s.int_word[7:0] = wb_dat_i[7:0];
        if (wb_sel_i[1]) nxt_s.int_word[15:8] = wb_dat_i[15:8];
        if (wb_sel_i[2]) nxt_s.fraction[7:0] = wb_dat_i[23:16];
        if (wb_sel_i[3]) begin
          nxt_s.fraction[11:8] = wb_dat_i[27:24];
          nxt_s.fastlock = wb_dat_i[31];
        end
        nxt_s.mod_active = s_ff.mod_staged;
        nxt_s.restart = 1'b1;
      end else if (wb_adr_i == `FSDI_ADR_REFDIV) begin
        if (wb_sel_i[0]) nxt_s.mod_staged[7:0] = wb_dat_i[7:0];
        if (wb_sel_i[1]) nxt_s.mod_staged[11:8] = wb_dat_i[11:8];
        if (wb_sel_i[2]) nxt_s.rdiv = wb_dat_i[19:16];
      end else if (wb_adr_i == `FSDI_ADR_NOISE) begin
        if (wb_sel_i[0]) nxt_s.mode = fsdi_mode_t'(wb_dat_i[1:0]);
      end else if (wb_adr_i == `FSDI_ADR_CONTROL) begin
        if (wb_sel_i[0]) begin
          nxt_s.cp_prog = wb_dat_i[3:0];
          nxt_s.doubler = wb_dat_i[4];
          nxt_s.mon_fl = wb_dat_i[5];
        end
      end
    end else if (rd) begin
      nxt_s.ack = 1'b1;
      nxt_s.rdat = 32'h0000_0000;
      if (wb_adr_i == `FSDI_ADR_FEEDBACK) begin
        nxt_s.rdat = {s_ff.fastlock, 3'h0, s_ff.fraction, s_ff.int_word};
      end else if (wb_adr_i == `FSDI_ADR_REFDIV) begin
        nxt_s.rdat = {12'h000, s_ff.rdiv, 4'h0, s_ff.mod_staged};
      end else if (wb_adr_i == `FSDI_ADR_NOISE) begin
        nxt_s.rdat = {30'h0, s_ff.mode};
      end else if (wb_adr_i == `FSDI_ADR_CONTROL) begin
        nxt_s.rdat = {26'h0, s_ff.mon_fl, s_ff.doubler, s_ff.cp_prog};
      end else begin
        // status: active modulus and last divide word
        nxt_s.rdat = {4'h0, s_ff.mod_active, s_ff.divide};
      end
    end
    // reference divider yields the detector tick
    if (ref_edge) begin
      if (s_ff.rcnt + 4'h1 >= rlim) begin
        nxt_s.rcnt = 4'h0;
        nxt_s.tick = 1'b1;
      end else begin
        nxt_s.rcnt = s_ff.rcnt + 4'h1;
      end
    end
    if (s_ff.tick) begin
      // 21-bit maximal sequence drives the dither
      nxt_s.lfsr = {s_ff.lfsr[19:0],
                    ^(s_ff.lfsr & `FSDI_LFSR_TAPS)};
    end
    if (s_ff.restart) begin
      nxt_s.lfsr = `FSDI_LFSR_SEED;
    end
    // carry lands in divide one clock after the stage update
    nxt_s.divide = INT_W'(signed'({1'b0, s_ff.int_word})
                          + INT_W'(carry));
    // fastlock forces max current, switch only if monitor selects it
    nxt_s.cp_out = s_ff.fastlock ? `FSDI_CP_MAX : s_ff.cp_prog;
    nxt_s.sw_out = s_ff.fastlock & s_ff.mon_fl;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_ff <= '0;
      s_ff.int_word <= `FSDI_INT_RST;
      s_ff.mod_staged <= `FSDI_MOD_RST;
      s_ff.mod_active <= `FSDI_MOD_RST;
      s_ff.lfsr <= `FSDI_LFSR_SEED;
      s_ff.cp_prog <= `FSDI_CP_RST;
      s_ff.divide <= `FSDI_INT_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign wb_ack_o = s_ff.ack;
  assign wb_dat_o = s_ff.rdat;
  assign pd_tick_o = s_ff.tick;
  assign divide_o = s_ff.divide;
  assign cp_current_o = s_ff.cp_out;
  assign fl_switch_o = s_ff.sw_out;
endmodule : fsdi_top
`default_nettype wire

/* fsdi_top_monitor.sv */
// Purpose: bus, tick and fastlock checks at the top ports
// Assumes: full-word writes, all byte lanes on
// Notes:   control bits are shadowed from bus writes
`timescale 1ns/10ps
`default_nettype none
`include "fsdi_defines.svh"
module fsdi_top_monitor #(
  parameter int MOD_W = 12,
  parameter int INT_W = 16
) (
  // clock, reset and bus
  input wire logic             clk_i,
  input wire logic             rst_i,
  input wire logic             wb_cyc_i,
  input wire logic             wb_stb_i,
  input wire logic             wb_we_i,
  input wire logic [3:0]       wb_adr_i,
  input wire logic [3:0]       wb_sel_i,
  input wire logic [31:0]      wb_dat_i,
  input wire logic [31:0]      wb_dat_o,
  input wire logic             wb_ack_o,
  // synthesizer
  input wire logic             ref_rise_i,
  input wire logic             ref_fall_i,
  input wire logic             pd_tick_o,
  input wire logic [INT_W-1:0] divide_o,
  input wire logic [3:0]       cp_current_o,
  input wire logic             fl_switch_o
);
  logic       take, wr_fb, fl_ff, mon_ff, dbl_ff;
  logic [3:0] cp_ff;
  assign take  = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_fb = take && wb_we_i && wb_adr_i == `FSDI_ADR_FEEDBACK;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {fl_ff, mon_ff, dbl_ff, cp_ff} <= '0;
    end else if (take && wb_we_i) begin
      if (wr_fb) fl_ff <= wb_dat_i[31];
      if (wb_adr_i == `FSDI_ADR_CONTROL) begin
        {mon_ff, dbl_ff, cp_ff} <= wb_dat_i[5:0];
      end
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack held");
  property p_ack_nxt; take |=> wb_ack_o; endproperty
  a_ack_nxt: assert property (p_ack_nxt) else $error("no ack");
  property p_ack_why; !take |=> !wb_ack_o; endproperty
  a_ack_why: assert property (p_ack_why) else $error("stray ack");
  property p_tick;
    pd_tick_o |-> $past(ref_fall_i) || $past(ref_rise_i) && $past(dbl_ff);
  endproperty
  a_tick: assert property (p_tick)
    else $error("stray tick");
  property p_fl_on;
    wr_fb && wb_dat_i[31] |-> ##2
      cp_current_o == `FSDI_CP_MAX && fl_switch_o == mon_ff;
  endproperty
  a_fl_on: assert property (p_fl_on)
    else $error("fastlock set");
  property p_fl_off;
    wr_fb && !wb_dat_i[31] |-> ##2 cp_current_o == cp_ff && !fl_switch_o;
  endproperty
  a_fl_off: assert property (p_fl_off)
    else $error("fastlock clear");
  property p_sw; fl_switch_o |-> $past(fl_ff) && $past(mon_ff); endproperty
  a_sw: assert property (p_sw) else $error("switch closed");
  property p_rst;
    $past(rst_i) |-> divide_o == `FSDI_INT_RST && !wb_ack_o
      && cp_current_o == `FSDI_CP_RST && !fl_switch_o;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  c_fast: cover property (wr_fb && wb_dat_i[31] && mon_ff);
  c_dbl: cover property (pd_tick_o && dbl_ff);
  c_read: cover property (take && !wb_we_i);
endmodule : fsdi_top_monitor
bind fsdi_top fsdi_top_monitor #(.MOD_W(MOD_W), .INT_W(INT_W)) u_mon (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
  .wb_dat_i, .wb_dat_o, .wb_ack_o, .ref_rise_i, .ref_fall_i, .pd_tick_o,
  .divide_o, .cp_current_o, .fl_switch_o);
`default_nettype wire

/* fsdi_host.sv */
// Purpose: bus host that programs the interpolator
// Assumes: ack within 20 cycles
// Notes:   stb follows cyc outside
`timescale 1ns/10ps
`default_nettype none
module fsdi_host (
  // bus
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] dat_i,
  output logic             cyc_o,
  output logic             we_o,
  output logic [3:0]       adr_o,
  output logic [31:0]      dat_o,
  output logic             tmo_o
);
  logic [31:0] rdat;
  initial begin
    {cyc_o, we_o, adr_o, dat_o, tmo_o} = '0;
  end
  task xfer(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    cyc_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    dat_o <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (!ack_i && n < 20);
    rdat = dat_i;
    tmo_o <= !ack_i;
    cyc_o <= 1'b0;
    @(posedge clk_i);
  endtask : xfer
  // R=1 keeps the detector at the reference rate
  task tune(input logic [11:0] m, input logic [11:0] f, input logic fl);
    xfer(1'b1, 4'h4, {12'h000, 4'h1, 4'h0, m});
    xfer(1'b1, 4'h0, {fl, 3'h0, f, 16'h0020});
  endtask : tune
endmodule : fsdi_host
`default_nettype wire

/* fsdi_top_test.sv */
// Purpose: directed test of the fractional interpolator
// Assumes: host model drives the bus, bench the reference
// Notes:   small moduli keep repeat lengths short
`timescale 1ns/10ps
`default_nettype none
`include "fsdi_defines.svh"
module fsdi_top_test;
  logic        clk_i, rst_i, rise, fall, cyc, we, tmo, tick, sw, ack;
  logic [3:0]  adr, cp;
  logic [31:0] wdat, rd;
  logic [15:0] div;
  logic [15:0] seq[$];
  logic [11:0] mods[4] = '{12'h002, 12'h009, 12'h006, 12'h005};
  int          lens[4] = '{4, 27, 36, 5};
  int          mismatches, compares, nticks;
  fsdi_host h (.clk_i(clk_i), .ack_i(ack), .dat_i(rd), .cyc_o(cyc),
    .we_o(we), .adr_o(adr), .dat_o(wdat), .tmo_o(tmo));
  fsdi_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(wdat), .wb_dat_o(rd), .wb_ack_o(ack), .ref_rise_i(rise),
    .ref_fall_i(fall), .pd_tick_o(tick), .divide_o(div),
    .cp_current_o(cp), .fl_switch_o(sw));
  task print_verdict;
    if (mismatches == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  task pulse(input logic r);
    rise <= r;
    fall <= !r;
    @(posedge clk_i);
    {rise, fall} <= 2'h0;
    repeat (4) @(posedge clk_i);
  endtask : pulse
  task run(input int n);
    repeat (n) begin
      pulse(1'b0);
      seq.push_back(div);
    end
  endtask : run
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (tick === 1'b1) nticks++;
    if (tmo === 1'b1) begin
      mismatches++;
      print_verdict();
    end
  end
  initial begin
    int l, s;
    {rst_i, rise, fall} = 3'h4;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("divide", div, `FSDI_INT_RST);
    h.xfer(1'b1, 4'h4, 32'h0001_0005);
    h.xfer(1'b0, 4'h2, 32'h0);
    chk("mod staged", h.rdat[27:16], 12'h002);
    h.xfer(1'b1, 4'h0, 32'h0002_0020);
    h.xfer(1'b0, 4'h2, 32'h0);
    chk("mod used", h.rdat[27:16], 12'h005);
    foreach (mods[i]) begin
      l = lens[i];
      s = 0;
      seq = {};
      h.tune(mods[i], 12'h001, 1'b0);
      run(l);
      h.tune(mods[i], 12'h001, 1'b0);
      run(2 * l);
      for (int k = 0; k < l; k++) begin
        chk("restart", seq[l+k], seq[k]);
        chk("repeat", seq[2*l+k], seq[l+k]);
        s += seq[l+k];
      end
      chk("average", s, l * 32 + l / mods[i]);
    end
    for (int md = 0; md < 4; md++) begin
      h.xfer(1'b1, 4'h8, 32'(md));
      seq = {};
      h.tune(12'h032, 12'h000, 1'b0);
      run(200);
      s = 0;
      foreach (seq[k]) s += (seq[k] != 16'h0020);
      chk("dither", s != 0, md == 2);
    end
    h.xfer(1'b1, 4'hc, 32'h0000_0003);
    h.xfer(1'b1, 4'h0, 32'h8000_0020);
    chk("cp fast", cp, `FSDI_CP_MAX);
    chk("switch", sw, 1'b0);
    h.xfer(1'b1, 4'h0, 32'h0000_0020);
    chk("cp slow", cp, 4'h3);
    h.xfer(1'b1, 4'hc, 32'h0000_0023);
    h.xfer(1'b1, 4'h0, 32'h8000_0020);
    chk("switch on", sw, 1'b1);
    h.xfer(1'b1, 4'h0, 32'h0000_0020);
    chk("switch off", sw, 1'b0);
    s = nticks;
    pulse(1'b1);
    chk("rise only", nticks - s, 0);
    h.xfer(1'b1, 4'hc, 32'h0000_0013);
    s = nticks;
    pulse(1'b1);
    pulse(1'b0);
    chk("both edges", nticks - s, 2);
    print_verdict();
  end
endmodule : fsdi_top_test
`default_nettype wire
